// [error_word_cfg.svh]
// Constants for the module error word encoder: field positions,
// class codes and extended codes.
// Assumes inclusion by bare name from the package and the encoder top module.
`ifndef ERROR_WORD_CFG_SVH
`define ERROR_WORD_CFG_SVH

// ***************************************************************
// Field positions of the 16-bit error word
// ***************************************************************
`define EW_PAD_HI       15
`define EW_PAD_LO       12
`define EW_CLASS_HI     11
`define EW_CLASS_LO     9
`define EW_EXT_HI       8
`define EW_EXT_LO       0
`define EW_PAD_VALUE    4'h0
`define EW_RESET_WORD   16'h0000

// ***************************************************************
// Error class codes
// ***************************************************************
`define EW_CLASS_NONE   3'h0
`define EW_CLASS_HW     3'h1
`define EW_CLASS_CFG    3'h2

// ***************************************************************
// Extended codes; channel codes are base plus channel number
// ***************************************************************
`define EW_EXT_ZERO     9'h000
`define EW_EXT_HW_GEN   9'h000
`define EW_EXT_POR      9'h001
`define EW_EXT_ASIC     9'h100
`define EW_EXT_CAL      9'h101
`define EW_EXT_ADC0     9'h10B
`define EW_EXT_CFG_GEN  9'h000
`define EW_EXT_TYPE0    9'h001
`define EW_EXT_FILT0    9'h007
`define EW_EXT_FMT0     9'h00D
`define EW_EXT_UNUSED0  9'h013
`define EW_EXT_MODULE   9'h019

`endif

// [error_word_pkg.sv]
// Types shared by the error word encoder modules.
// Assumes error_word_cfg.svh is on the include path.
`default_nettype none
`include "error_word_cfg.svh"

package error_word_pkg;
   typedef logic [2:0]  err_class_t;
   typedef logic [8:0]  ext_code_t;
   typedef logic [15:0] err_word_t;
endpackage

`default_nettype wire

// [lowest_set_pick.sv]
// Lowest-index picker over a vector of fault flags.
// Assumes purely combinational use inside a clocked parent.
`timescale 1ns/1ps
`default_nettype none

module lowest_set_pick #(
   parameter int WIDTH = 6,
   parameter int IDX_W = 3
) (
   input  wire logic [WIDTH-1:0] flags_in,
   output logic                  any_out,
   output logic [IDX_W-1:0]      index_out
);

   // ************************************************************
   // Scan from the top so the lowest set flag wins
   // ************************************************************
   always_comb begin
      any_out   = 1'b0;
      index_out = '0;
      for (int i = WIDTH - 1; i >= 0; i--) begin
         if (flags_in[i]) begin
            any_out   = 1'b1;
            index_out = IDX_W'(i);
         end
      end
   end

endmodule

`default_nettype wire

// [error_word_encoder.sv]
// Top of the module error word encoder: fault flags in, one
// registered 16-bit error word out.
// Assumes all fault flags are levels synchronous to clock_in.
`timescale 1ns/1ps
`default_nettype none
`include "error_word_cfg.svh"

module error_word_encoder
   import error_word_pkg::*;
#(
   parameter int NUM_CH = 6,
   parameter int CH_W   = 3
) (
   input  wire logic              clock_in,
   input  wire logic              rst_in,
   input  wire logic              enable_in,
   input  wire logic              por_state_in,
   input  wire logic              hw_general_in,
   input  wire logic              asic_fault_in,
   input  wire logic              cal_fault_in,
   input  wire logic [NUM_CH-1:0] adc_fault_in,
   input  wire logic              cfg_general_in,
   input  wire logic [NUM_CH-1:0] cfg_type_bad_in,
   input  wire logic [NUM_CH-1:0] cfg_filter_bad_in,
   input  wire logic [NUM_CH-1:0] cfg_format_bad_in,
   input  wire logic [NUM_CH-1:0] cfg_unused_bad_in,
   input  wire logic              cfg_module_bad_in,
   output logic [15:0]            error_word_out,
   output logic                   word_changed_out
);

   // ************************************************************
   // Code arithmetic
   // ************************************************************
   // Channel code from a base code and a channel number
   function automatic ext_code_t chan_code(input ext_code_t base,
                                           input logic [CH_W-1:0] ch);
      chan_code = base + ext_code_t'(ch);
   endfunction

   // ************************************************************
   // Channel pickers
   // ************************************************************
   logic              adc_any;
   logic [CH_W-1:0]   adc_ch;
   logic              cfg_ch_any;
   logic [CH_W-1:0]   cfg_ch;
   wire  [NUM_CH-1:0] cfg_chan_bad;

   // Any configuration fault on a channel
   assign cfg_chan_bad = cfg_type_bad_in | cfg_filter_bad_in |
                         cfg_format_bad_in | cfg_unused_bad_in;

   lowest_set_pick #(.WIDTH(NUM_CH), .IDX_W(CH_W)) u_adc_pick (
      .flags_in  (adc_fault_in),
      .any_out   (adc_any),
      .index_out (adc_ch)
   );

   lowest_set_pick #(.WIDTH(NUM_CH), .IDX_W(CH_W)) u_cfg_pick (
      .flags_in  (cfg_chan_bad),
      .any_out   (cfg_ch_any),
      .index_out (cfg_ch)
   );

   // ************************************************************
   // Priority selection
   // ************************************************************
   wire        hw_any;
   wire        cfg_any;
   ext_code_t  hw_ext;
   ext_code_t  cfg_chan_ext;
   ext_code_t  cfg_ext;
   err_class_t class_sel;
   ext_code_t  ext_sel;
   err_word_t  word_nxt;

   // Fault presence per class
   assign hw_any  = por_state_in | hw_general_in | asic_fault_in |
                    cal_fault_in | adc_any;
   assign cfg_any = cfg_ch_any | cfg_module_bad_in | cfg_general_in;

   // Hardware code, specific before general
   assign hw_ext = por_state_in  ? `EW_EXT_POR :
                   asic_fault_in ? `EW_EXT_ASIC :
                   cal_fault_in  ? `EW_EXT_CAL :
                   adc_any ? chan_code(`EW_EXT_ADC0, adc_ch) :
                   `EW_EXT_HW_GEN;

   // Code of the lowest faulty channel, type first
   assign cfg_chan_ext =
      cfg_type_bad_in[cfg_ch]   ? chan_code(`EW_EXT_TYPE0, cfg_ch) :
      cfg_filter_bad_in[cfg_ch] ? chan_code(`EW_EXT_FILT0, cfg_ch) :
      cfg_format_bad_in[cfg_ch] ? chan_code(`EW_EXT_FMT0, cfg_ch) :
      chan_code(`EW_EXT_UNUSED0, cfg_ch);

   // Configuration code, channels before module, general last
   assign cfg_ext = cfg_ch_any        ? cfg_chan_ext :
                    cfg_module_bad_in ? `EW_EXT_MODULE :
                    `EW_EXT_CFG_GEN;

   // Hardware outranks configuration; no fault gives zero code
   assign class_sel = hw_any  ? `EW_CLASS_HW :
                      cfg_any ? `EW_CLASS_CFG :
                      `EW_CLASS_NONE;
   assign ext_sel   = hw_any  ? hw_ext :
                      cfg_any ? cfg_ext :
                      `EW_EXT_ZERO;
   assign word_nxt  = {`EW_PAD_VALUE, class_sel, ext_sel};

   // ************************************************************
   // Output registers
   // ************************************************************
   err_word_t word_r;
   logic      changed_r;

   // Word register, frozen while enable is low
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         word_r    <= `EW_RESET_WORD;
         changed_r <= 1'b0;
      end else if (enable_in) begin
         word_r    <= word_nxt;
         changed_r <= (word_nxt != word_r);
      end
   end

   assign error_word_out   = word_r;
   assign word_changed_out = changed_r;

   // ************************************************************
   // Checks
   // ************************************************************
   logic started_r;

   // Marks that one enabled edge has passed since reset
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         started_r <= 1'b0;
      end else if (enable_in) begin
         started_r <= 1'b1;
      end
   end

   chk_spare_zero: assert property (@(posedge clock_in)
      disable iff (rst_in)
      word_r[`EW_PAD_HI:`EW_PAD_LO] == 4'h0)
      else $error("spare bits of error word not zero");

   chk_none_clear: assert property (@(posedge clock_in)
      disable iff (rst_in)
      word_r[11:9] == 3'h0 |-> word_r[8:0] == 9'h000)
      else $error("extended code set with no error class");

   chk_class_legal: assert property (@(posedge clock_in)
      disable iff (rst_in)
      word_r[11:9] inside {3'h0, 3'h1, 3'h2})
      else $error("illegal error class");

   chk_por_code: assert property (@(posedge clock_in)
      disable iff (rst_in)
      started_r && $past(enable_in) && $past(por_state_in)
      |-> word_r == 16'h0201)
      else $error("power-up state not reported as 0201");

   chk_asic_code: assert property (@(posedge clock_in)
      disable iff (rst_in)
      started_r && $past(enable_in) && $past(asic_fault_in) &&
      !$past(por_state_in) |-> word_r == 16'h0300)
      else $error("asic fault not reported as 0300");

   chk_cal_code: assert property (@(posedge clock_in)
      disable iff (rst_in)
      started_r && $past(enable_in) && $past(cal_fault_in) &&
      !$past(por_state_in) && !$past(asic_fault_in)
      |-> word_r == 16'h0301)
      else $error("calibration fault not reported as 0301");

   chk_adc5_code: assert property (@(posedge clock_in)
      disable iff (rst_in)
      started_r && $past(enable_in) && $past(adc_fault_in) == 6'h20 &&
      !$past(por_state_in | asic_fault_in | cal_fault_in)
      |-> word_r == 16'h0310)
      else $error("channel 5 converter fault not reported as 0310");

   chk_hw_first: assert property (@(posedge clock_in)
      disable iff (rst_in)
      started_r && $past(enable_in) && $past(hw_any)
      |-> word_r[11:9] == 3'h1)
      else $error("hardware fault not given priority");

   chk_cfg_class: assert property (@(posedge clock_in)
      disable iff (rst_in)
      started_r && $past(enable_in) && $past(cfg_any) && !$past(hw_any)
      |-> word_r[11:9] == 3'h2)
      else $error("configuration fault not reported as class 2");

   chk_cfg_general: assert property (@(posedge clock_in)
      disable iff (rst_in)
      started_r && $past(enable_in) && !$past(hw_any) &&
      $past(cfg_general_in) && $past(cfg_chan_bad) == 6'h00 &&
      !$past(cfg_module_bad_in) |-> word_r == 16'h0400)
      else $error("general configuration fault not 0400");

   chk_module_bit: assert property (@(posedge clock_in)
      disable iff (rst_in)
      started_r && $past(enable_in) && !$past(hw_any) &&
      $past(cfg_chan_bad) == 6'h00 && $past(cfg_module_bad_in)
      |-> word_r == 16'h0419)
      else $error("module configuration bit fault not 0419");

   chk_low_channel: assert property (@(posedge clock_in)
      disable iff (rst_in)
      started_r && $past(enable_in) && !$past(hw_any) &&
      $past(cfg_type_bad_in[0]) |-> word_r == 16'h0401)
      else $error("channel 0 input type fault not 0401");

   chk_freeze: assert property (@(posedge clock_in)
      disable iff (rst_in)
      started_r && !$past(enable_in) |-> $stable(word_r))
      else $error("error word changed while enable low");

endmodule

`default_nettype wire

// [status_reader.sv]
// Far-side model: bus-master controller reading the error word.
// Assumes the word is sampled on the rising edge of clock_in.
`timescale 1ns/1ps
`default_nettype none

module status_reader (
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   input  wire logic [15:0] word_in,
   output logic [8:0]       ext_seen_out
);
   // Extended code taken only while the class is non-zero
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         ext_seen_out <= 9'h000;
      end else if (word_in[11:9] != 3'h0) begin
         ext_seen_out <= word_in[8:0];
      end
   end
endmodule

`default_nettype wire

// [testbench.sv]
// Self-checking bench for the error word encoder.
// Assumes one 50 MHz clock and level fault flags driven at the edge.
`timescale 1ns/1ps
`default_nettype none

module testbench
   import error_word_pkg::*;
;
   logic        clock_in = 0;
   logic        rst_in = 1;
   logic        enable_in = 1;
   logic        por_state_in = 0, hw_general_in = 0;
   logic        asic_fault_in = 0, cal_fault_in = 0;
   logic [5:0]  adc_fault_in = 0, cfg_type_bad_in = 0;
   logic [5:0]  cfg_filter_bad_in = 0, cfg_format_bad_in = 0;
   logic [5:0]  cfg_unused_bad_in = 0;
   logic        cfg_general_in = 0, cfg_module_bad_in = 0;
   err_word_t   error_word_out;
   logic        word_changed_out;
   logic [8:0]  ext_seen;
   int          err_count = 0, total_checks = 0, cycles = 0;

   error_word_encoder i_error_word_encoder (
      .clock_in          (clock_in),
      .rst_in            (rst_in),
      .enable_in         (enable_in),
      .por_state_in      (por_state_in),
      .hw_general_in     (hw_general_in),
      .asic_fault_in     (asic_fault_in),
      .cal_fault_in      (cal_fault_in),
      .adc_fault_in      (adc_fault_in),
      .cfg_general_in    (cfg_general_in),
      .cfg_type_bad_in   (cfg_type_bad_in),
      .cfg_filter_bad_in (cfg_filter_bad_in),
      .cfg_format_bad_in (cfg_format_bad_in),
      .cfg_unused_bad_in (cfg_unused_bad_in),
      .cfg_module_bad_in (cfg_module_bad_in),
      .error_word_out    (error_word_out),
      .word_changed_out  (word_changed_out)
   );

   status_reader i_status_reader (
      .clock_in     (clock_in),
      .rst_in       (rst_in),
      .word_in      (error_word_out),
      .ext_seen_out (ext_seen)
   );

   // ***********************************************
   // Clock, timeout and shared tasks
   // ***********************************************
   always #10 clock_in = ~clock_in;

   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      if (cycles == 500) begin
         err_count++;
         summarize();
      end
   end

   task automatic summarize();
      if (err_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // Design takes inputs at the next rising edge; read at the fall
   task automatic step();
      @(posedge clock_in);
      @(negedge clock_in);
   endtask

   // Inputs change on a rising edge; cf is {unused, format, filter, type}
   task automatic drive(input logic [3:0]  hw,
                        input logic [5:0]  adc,
                        input logic [23:0] cf,
                        input logic [2:0]  misc);
      @(posedge clock_in);
      {por_state_in, asic_fault_in, cal_fault_in, hw_general_in} <= hw;
      adc_fault_in      <= adc;
      cfg_type_bad_in   <= cf[5:0];
      cfg_filter_bad_in <= cf[11:6];
      cfg_format_bad_in <= cf[17:12];
      cfg_unused_bad_in <= cf[23:18];
      {cfg_module_bad_in, cfg_general_in, enable_in} <= misc;
   endtask

   // ***********************************************
   // Scenarios
   // ***********************************************
   task automatic sc_hardware();
      logic [3:0][15:0] chain;
      logic [3:0][3:0]  hw;
      chain = {16'h0200, 16'h0301, 16'h0300, 16'h0201};
      hw    = {4'h1, 4'h3, 4'h7, 4'hF};
      for (int i = 0; i < 4; i++) begin
         drive(hw[i], 6'h00, 24'hFFFFFF, 3'h7);
         step();
         chk(error_word_out, chain[i]);
      end
      for (int n = 0; n < 6; n++) begin
         drive(4'h1, 6'(6'h3F << n), 24'hFFFFFF, 3'h7);
         step();
         chk(error_word_out, 16'(16'h030B + n));
      end
   endtask

   task automatic sc_config();
      logic [5:0] fld;
      for (int k = 0; k < 4; k++) begin
         for (int n = 0; n < 6; n++) begin
            fld = 6'(6'h3F << n);
            drive(4'h0, 6'h00, 24'(fld) << (6 * k), 3'h7);
            step();
            chk(error_word_out, 16'(16'h0401 + 6 * k + n));
         end
      end
      // Filter on channel 0 beats type on channel 5
      drive(4'h0, 6'h00, 24'h000060, 3'h1);
      step();
      chk(error_word_out, 16'h0407);
      // Type beats unused bit on the same channel
      drive(4'h0, 6'h00, 24'h100004, 3'h1);
      step();
      chk(error_word_out, 16'h0403);
      drive(4'h0, 6'h00, 24'h000000, 3'h7);
      step();
      chk(error_word_out, 16'h0419);
      drive(4'h0, 6'h00, 24'h000000, 3'h3);
      step();
      chk(error_word_out, 16'h0400);
   endtask

   task automatic sc_hold_clear();
      drive(4'h0, 6'h04, 24'h000000, 3'h1);
      step();
      chk(error_word_out, 16'h030D);
      chk({15'h0, word_changed_out}, 16'h0001);
      step();
      chk({15'h0, word_changed_out}, 16'h0000);
      drive(4'h0, 6'h00, 24'h000000, 3'h0);
      step();
      chk(error_word_out, 16'h030D);
      drive(4'h0, 6'h00, 24'h000000, 3'h1);
      step();
      chk(error_word_out, 16'h0000);
      step();
      chk({7'h0, ext_seen}, 16'h010D);
   endtask

   // Reset in mid-run, then the first edge after release loads the word
   task automatic sc_reset();
      drive(4'h0, 6'h01, 24'h000000, 3'h1);
      step();
      chk(error_word_out, 16'h030B);
      @(posedge clock_in);
      rst_in <= 1'b1;
      @(negedge clock_in);
      chk(error_word_out, 16'h0000);
      chk({15'h0, word_changed_out}, 16'h0000);
      @(posedge clock_in);
      rst_in <= 1'b0;
      step();
      chk(error_word_out, 16'h030B);
      chk({15'h0, word_changed_out}, 16'h0001);
   endtask

   // ***********************************************
   // Main sequence
   // ***********************************************
   initial begin
      repeat (6) @(posedge clock_in);
      rst_in <= 0;
      step();
      chk(error_word_out, 16'h0000);
      sc_hardware();
      sc_config();
      sc_hold_clear();
      sc_reset();
      summarize();
   end
endmodule

`default_nettype wire
